// [rtl/cige_regs.svh]
// Register offsets, field positions, reset values and opcodes for the instruction group unit
`ifndef CIGE_REGS_SVH
`define CIGE_REGS_SVH
`define CIGE_OFF_CMD      12'h000
`define CIGE_OFF_OPA      12'h004
`define CIGE_OFF_OPB      12'h008
`define CIGE_OFF_PC       12'h00c
`define CIGE_OFF_TCP      12'h010
`define CIGE_OFF_STP      12'h014
`define CIGE_OFF_FLAGS    12'h018
`define CIGE_OFF_SYSMODE  12'h01c
`define CIGE_OFF_RESULT   12'h020
`define CIGE_OFF_STATUS   12'h024
`define CIGE_OFF_IRQPEND  12'h028
`define CIGE_OFF_MEMDATA  12'h02c
`define CIGE_OFF_MEMADDR  12'h030
`define CIGE_GIE_BIT      0
`define CIGE_FLAG_C       7
`define CIGE_FLAG_Z       6
`define CIGE_FLAG_S       5
`define CIGE_FLAG_V       4
`define CIGE_OP_DIV       8'h94
`define CIGE_OP_LOOP      8'h0a
`define CIGE_OP_IRQ_ON    8'h9f
`define CIGE_OP_IRQ_OFF   8'h8f
`define CIGE_OP_ENTER     8'h1f
`define CIGE_OP_EXIT      8'h2f
`define CIGE_OP_IDLE      8'h6f
`define CIGE_OP_INC       8'h20
`define CIGE_OP_ADD_ONE_WORD_OP      8'ha0
`define CIGE_RST_SP       16'h0100
`define CIGE_STEP_TWO     16'h0002
`endif

// [rtl/cige_pkg.sv]
// Types shared by the instruction group unit
package cige_pkg;
    typedef enum logic [2:0] {
        CIGE_IDLE_ST  = 3'b000,
        CIGE_PUSH_ST  = 3'b001,
        CIGE_POP_ST   = 3'b010,
        CIGE_FETCH_ST = 3'b011,
        CIGE_SLEEP_ST = 3'b100
    } cige_state_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        we;
        logic        req;
    } cige_mem_t;
endpackage

// [rtl/cige_exec.sv]
// Execution unit for divide, loop branch, interrupt enable, thread enter/exit, idle and increment
//
// Operation
// - Divide pair; remainder high, quotient low
// - Loop decrements register, branches when nonzero
// - Displacement added to next-instruction address
// - All but the two increments leave flags unchanged
// - Interrupt enable sets system mode bit 0
// - Pending interrupt serviced after enable executes
// - Enter pushes pointer, swaps, fetches, adds two
// - Exit pops pointer, fetches, adds two
// - Idle gates CPU clock, oscillator runs
// - Interrupt request or reset leaves idle
// - Byte increment sets zero, sign, overflow
// - Word increment on even pair, same flags
// - Disabled interrupts still latch pending bits
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cige_regs.svh"
module cige_exec (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  irq_req,
    output logic             cpu_clk_en,
    output logic             irq_service
);
    cige_pkg::cige_state_t state_q;
    logic [31:0] cmd_q;
    logic [15:0] opa_q;
    logic [15:0] opb_q;
    logic [15:0] pc_q;
    logic [15:0] tcp_q;
    logic [15:0] sp_q;
    logic [7:0]  flags_q;
    logic [7:0]  sysmode_q;
    logic [15:0] result_q;
    logic [7:0]  pend_q;
    logic [15:0] stack_mem_q [0:127];
    logic [15:0] prog_mem_q  [0:127];
    logic [7:0]  irq_s1_q;
    logic [7:0]  irq_s2_q;
    logic        svc_q;
    logic        div_err_q;
    logic        wr_en;
    logic        rd_en;
    logic        map_ok;
    logic [15:0] mem_addr_q;
    logic        idle_st;
    logic        cmd_wr;
    logic        pc_wr;
    logic        tcp_wr;
    logic        sp_wr;
    logic        flags_wr;
    logic        sys_wr;
    logic        div_bad;
    logic [7:0]  opcode;
    logic [7:0]  dec_b;
    logic [7:0]  inc_b;
    logic [15:0] inc_w;

    // Index of a 16-bit word inside a small word memory
    function automatic logic [6:0] word_idx(input logic [15:0] a);
        word_idx = a[7:1];
    endfunction

    // Zero, sign and overflow for an increment of the given width
    function automatic logic [7:0] inc_flags(input logic [7:0] f, input logic z,
                                             input logic s, input logic v);
        logic [7:0] r;
        r = f;
        r[`CIGE_FLAG_Z] = z;
        r[`CIGE_FLAG_S] = s;
        r[`CIGE_FLAG_V] = v;
        inc_flags = r;
    endfunction

    // Loop target: next-instruction address plus the sign-extended displacement when taken
    function automatic logic [15:0] loop_pc(input logic [15:0] pc, input logic [7:0] disp,
                                            input logic take);
        logic [15:0] step;
        step    = take ? {{8{disp[7]}}, disp} : 16'h0000;
        loop_pc = 16'(pc + `CIGE_STEP_TWO + step);
    endfunction

    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & ~penable & ~pwrite;
    assign pready  = 1'b1;
    assign map_ok  = (paddr <= `CIGE_OFF_MEMADDR) && (paddr[1:0] == 2'b00);
    assign pslverr = psel & penable & ~map_ok;

    // Software writes to core registers are refused while an instruction is in flight
    assign idle_st  = (state_q == cige_pkg::CIGE_IDLE_ST);
    assign cmd_wr   = wr_en && idle_st && (paddr == `CIGE_OFF_CMD);
    assign pc_wr    = wr_en && idle_st && (paddr == `CIGE_OFF_PC);
    assign tcp_wr   = wr_en && idle_st && (paddr == `CIGE_OFF_TCP);
    assign sp_wr    = wr_en && idle_st && (paddr == `CIGE_OFF_STP);
    assign flags_wr = wr_en && idle_st && (paddr == `CIGE_OFF_FLAGS);
    assign sys_wr   = wr_en && idle_st && (paddr == `CIGE_OFF_SYSMODE);

    // Opcode and the arithmetic that several registers share
    assign opcode   = pwdata[7:0];
    assign dec_b    = 8'(opa_q[7:0] - 8'h01);
    assign inc_b    = 8'(opa_q[7:0] + 8'h01);
    assign inc_w    = 16'(opa_q + 16'h0001);
    assign div_bad  = (opb_q[7:0] == 8'h00) || (opa_q[15:8] >= opb_q[7:0]);

    // Interrupt request lines arrive from outside the clock domain
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_s1_q <= 8'h00;
            irq_s2_q <= 8'h00;
        end
        else
        begin
            irq_s1_q <= irq_req;
            irq_s2_q <= irq_s1_q;
        end
    end

    // Pending bits latch regardless of the global enable; set beats clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pend_q <= 8'h00;
        else if (wr_en && paddr == `CIGE_OFF_IRQPEND)
            pend_q <= (pend_q & ~pwdata[7:0]) | irq_s2_q;
        else
            pend_q <= pend_q | irq_s2_q;
    end

    // Service strobe only while globally enabled and awake; held pendings fire on enable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            svc_q <= 1'b0;
        else
            svc_q <= sysmode_q[`CIGE_GIE_BIT] && (pend_q != 8'h00)
                     && state_q != cige_pkg::CIGE_SLEEP_ST;
    end
    assign irq_service = svc_q;

    // CPU clock gate follows the sleep state; oscillator and pclk keep running
    assign cpu_clk_en = (state_q != cige_pkg::CIGE_SLEEP_ST);

    // Operand and memory-window registers written by software
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            opa_q      <= 16'h0000;
            opb_q      <= 16'h0000;
            mem_addr_q <= 16'h0000;
        end
        else if (wr_en)
        begin
            if (paddr == `CIGE_OFF_OPA)
                opa_q <= pwdata[15:0];
            if (paddr == `CIGE_OFF_OPB)
                opb_q <= pwdata[15:0];
            if (paddr == `CIGE_OFF_MEMADDR)
                mem_addr_q <= pwdata[15:0];
        end
    end

    // Program memory written by software through the window
    always_ff @(posedge pclk)
    begin
        if (wr_en && paddr == `CIGE_OFF_MEMDATA)
            prog_mem_q[word_idx(mem_addr_q)] <= pwdata[15:0];
    end

    // Stack memory written by the enter sequence
    always_ff @(posedge pclk)
    begin
        if (state_q == cige_pkg::CIGE_PUSH_ST)
            stack_mem_q[word_idx(sp_q)] <= tcp_q;
    end

    // Sequencer: enter and exit walk push or pop, then fetch; idle sleeps until a request
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_q <= cige_pkg::CIGE_IDLE_ST;
        else
        begin
            case (state_q)
                cige_pkg::CIGE_IDLE_ST:
                begin
                    if (cmd_wr && opcode == `CIGE_OP_ENTER)
                        state_q <= cige_pkg::CIGE_PUSH_ST;
                    else if (cmd_wr && opcode == `CIGE_OP_EXIT)
                        state_q <= cige_pkg::CIGE_POP_ST;
                    else if (cmd_wr && opcode == `CIGE_OP_IDLE)
                        state_q <= cige_pkg::CIGE_SLEEP_ST;
                end
                cige_pkg::CIGE_PUSH_ST:
                    state_q <= cige_pkg::CIGE_FETCH_ST;
                cige_pkg::CIGE_POP_ST:
                    state_q <= cige_pkg::CIGE_FETCH_ST;
                cige_pkg::CIGE_FETCH_ST:
                    state_q <= cige_pkg::CIGE_IDLE_ST;
                cige_pkg::CIGE_SLEEP_ST:
                begin
                    if (irq_s2_q != 8'h00)
                        state_q <= cige_pkg::CIGE_IDLE_ST;
                end
                default:
                    state_q <= cige_pkg::CIGE_IDLE_ST;
            endcase
        end
    end

    // Last command word, kept for readback
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cmd_q <= 32'h0000_0000;
        else if (cmd_wr)
            cmd_q <= pwdata;
    end

    // Program counter: software load, loop branch, or the word fetched by enter and exit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pc_q <= 16'h0000;
        else if (pc_wr)
            pc_q <= pwdata[15:0];
        else if (cmd_wr && opcode == `CIGE_OP_LOOP)
            pc_q <= loop_pc(pc_q, opb_q[7:0], dec_b != 8'h00);
        else if (state_q == cige_pkg::CIGE_FETCH_ST)
            pc_q <= prog_mem_q[word_idx(tcp_q)];
    end

    // Threaded-code pointer: saved on push, reloaded on pop, stepped past the fetched word
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tcp_q <= 16'h0000;
        else if (tcp_wr)
            tcp_q <= pwdata[15:0];
        else if (state_q == cige_pkg::CIGE_PUSH_ST)
            tcp_q <= pc_q;
        else if (state_q == cige_pkg::CIGE_POP_ST)
            tcp_q <= stack_mem_q[word_idx(sp_q)];
        else if (state_q == cige_pkg::CIGE_FETCH_ST)
            tcp_q <= 16'(tcp_q + `CIGE_STEP_TWO);
    end

    // Stack pointer: enter moves it down before the push, exit up after the pop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sp_q <= `CIGE_RST_SP;
        else if (sp_wr)
            sp_q <= pwdata[15:0];
        else if (cmd_wr && opcode == `CIGE_OP_ENTER)
            sp_q <= 16'(sp_q - `CIGE_STEP_TWO);
        else if (state_q == cige_pkg::CIGE_POP_ST)
            sp_q <= 16'(sp_q + `CIGE_STEP_TWO);
    end

    // Flags change only by software or increment; carry and the low bits stay put
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flags_q <= 8'h00;
        else if (flags_wr)
            flags_q <= pwdata[7:0];
        else if (cmd_wr && opcode == `CIGE_OP_INC)
            flags_q <= inc_flags(flags_q, inc_b == 8'h00, inc_b[7],
                                 opa_q[7:0] == 8'h7f);
        else if (cmd_wr && opcode == `CIGE_OP_ADD_ONE_WORD_OP)
            flags_q <= inc_flags(flags_q, inc_w == 16'h0000, inc_w[15],
                                 opa_q == 16'h7fff);
        else
            flags_q <= flags_q;
    end

    // System mode: the global interrupt enable bit is driven by the on and off opcodes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sysmode_q <= 8'h00;
        else if (sys_wr)
            sysmode_q <= pwdata[7:0];
        else if (cmd_wr && opcode == `CIGE_OP_IRQ_ON)
            sysmode_q[`CIGE_GIE_BIT] <= 1'b1;
        else if (cmd_wr && opcode == `CIGE_OP_IRQ_OFF)
            sysmode_q[`CIGE_GIE_BIT] <= 1'b0;
    end

    // Result of divide, loop count and increment; a bad divide keeps the old result
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            result_q <= 16'h0000;
        else if (cmd_wr)
        begin
            case (opcode)
                `CIGE_OP_DIV:
                begin
                    if (!div_bad)
                        result_q <= {8'(opa_q % {8'h00, opb_q[7:0]}),
                                     8'(opa_q / {8'h00, opb_q[7:0]})};
                end
                `CIGE_OP_LOOP:
                    result_q <= {8'h00, dec_b};
                `CIGE_OP_INC:
                    result_q <= {8'h00, inc_b};
                `CIGE_OP_ADD_ONE_WORD_OP:
                    result_q <= inc_w;
                default:
                    result_q <= result_q;
            endcase
        end
    end

    // Divide error: divisor zero or a quotient too wide for one byte
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_err_q <= 1'b0;
        else if (cmd_wr && opcode == `CIGE_OP_DIV)
            div_err_q <= div_bad;
    end

    // Read multiplexer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (rd_en)
        begin
            case (paddr)
                `CIGE_OFF_CMD:     prdata <= cmd_q;
                `CIGE_OFF_OPA:     prdata <= {16'h0000, opa_q};
                `CIGE_OFF_OPB:     prdata <= {16'h0000, opb_q};
                `CIGE_OFF_PC:      prdata <= {16'h0000, pc_q};
                `CIGE_OFF_TCP:     prdata <= {16'h0000, tcp_q};
                `CIGE_OFF_STP:     prdata <= {16'h0000, sp_q};
                `CIGE_OFF_FLAGS:   prdata <= {24'h000000, flags_q};
                `CIGE_OFF_SYSMODE: prdata <= {24'h000000, sysmode_q};
                `CIGE_OFF_RESULT:  prdata <= {16'h0000, result_q};
                `CIGE_OFF_STATUS:  prdata <= {27'h0, div_err_q, 1'b0, state_q};
                `CIGE_OFF_IRQPEND: prdata <= {24'h000000, pend_q};
                `CIGE_OFF_MEMADDR: prdata <= {16'h0000, mem_addr_q};
                default:           prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule
`default_nettype wire

// [bench/cige_checker.sv]
// Port-level assertions for the instruction group unit
`timescale 1ns/1ps
`default_nettype none
`include "cige_regs.svh"
module cige_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  irq_req,
    input wire logic        cpu_clk_en,
    input wire logic        irq_service
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Access phase and bad address decode
    wire logic acc = psel && penable;
    wire logic bad = (paddr > `CIGE_OFF_MEMADDR) || (paddr[1:0] != 2'b00);
    wire logic idl = acc && pwrite && paddr == `CIGE_OFF_CMD && pwdata[7:0] == `CIGE_OP_IDLE;
    AST_READY: assert property (acc |-> pready) else $error("pready low in access");
    AST_ERR_BAD: assert property (acc && bad |-> pslverr) else $error("no error on bad address");
    AST_ERR_OK: assert property (acc && !bad |-> !pslverr) else $error("error on good address");
    AST_ERR_IDLE: assert property (!acc |-> !pslverr) else $error("error outside access");
    AST_UNMAP_ZERO: assert property (acc && !pwrite && paddr > `CIGE_OFF_MEMADDR |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    AST_RDATA_HOLD: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved");
    AST_IDLE_GATE: assert property (idl && cpu_clk_en && irq_req == 8'h00 |=> !cpu_clk_en)
        else $error("idle did not gate clock");
    AST_SLEEP_NO_SVC: assert property (!cpu_clk_en [*2] |-> !irq_service)
        else $error("service while asleep");
    AST_WAKE: assert property ((irq_req != 8'h00) [*5] |-> cpu_clk_en)
        else $error("no wake on request");
    // Main scenarios
    COV_IDLE: cover property (idl);
    COV_SLEEP: cover property (!cpu_clk_en);
    COV_SVC: cover property (irq_service);
endmodule
bind cige_exec cige_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_req(irq_req), .cpu_clk_en(cpu_clk_en),
    .irq_service(irq_service));
`default_nettype wire

// [bench/tb_top.sv]
// Self-checking bench for the instruction group unit
`timescale 1ns/1ps
`default_nettype none
`include "cige_regs.svh"
module tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  irq_req = 8'h00;
    logic        cpu_clk_en;
    logic        irq_service;
    logic [31:0] seed = 32'd43140;
    logic [31:0] rd;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] f;
    logic [31:0] p;
    logic [31:0] t;
    logic [7:0]  n;
    logic        serr;
    int          err_count = 0;
    int          n_compared = 0;
    int          cycles = 0;
    cige_exec dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_req(irq_req), .cpu_clk_en(cpu_clk_en),
        .irq_service(irq_service));
    // Clock and run ceiling
    always #5 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            err_count++;
            report_and_stop();
        end
    end
    // Xorshift source
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Expected flags and result of byte or word increment
    function automatic logic [31:0] inc_exp(input logic [15:0] v, input logic w,
                                            input logic [7:0] g);
        logic [15:0] r;
        r = w ? v + 16'h1 : {8'h0, v[7:0] + 8'h1};
        g[6] = (r == 16'h0);
        g[5] = w ? r[15] : r[7];
        g[4] = w ? (v == 16'h7fff) : (v[7:0] == 8'h7f);
        return {8'h0, g, r};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; read data and error taken at the pready edge
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 100)
        begin
            @(posedge pclk);
            k++;
        end
        if (k == 100)
        begin
            err_count++;
            $display("mismatch at %0t: no ready", $time);
        end
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [11:0] ad, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, ad, 32'h0);
        check(rd & m, e);
    endtask
    // Load operands, issue opcode, poll until the unit is idle
    task automatic exec(input logic [7:0] op, input logic [31:0] x, input logic [31:0] y);
        int k;
        apb(1'b1, `CIGE_OFF_OPA, x);
        apb(1'b1, `CIGE_OFF_OPB, y);
        apb(1'b1, `CIGE_OFF_CMD, {24'h0, op});
        k = 0;
        rd = 32'h1;
        while (rd[2:0] != 3'b000 && k < 50)
        begin
            apb(1'b0, `CIGE_OFF_STATUS, 32'h0);
            k++;
        end
        if (k == 50)
        begin
            err_count++;
            $display("mismatch at %0t: unit stays busy", $time);
        end
    endtask
    task automatic report_and_stop();
        if (err_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check({31'h0, cpu_clk_en}, 32'h1);
        for (int i = 1; i <= 10; i++)
            rchk(12'(i * 4), 32'hffff, (i == 5) ? 32'h100 : 32'h0);
        rchk(12'h034, 32'hffffffff, 32'h0);
        check({31'h0, serr}, 32'h1);
        apb(1'b0, 12'h006, 32'h0);
        check({31'h0, serr}, 32'h1);
        for (int i = 0; i < 12; i++)
        begin
            a = (i < 4) ? 32'(64'h7fff_007f_ffff_00ff >> (i * 16)) & 32'hffff : rnd();
            f = rnd() & 32'hf0;
            apb(1'b1, `CIGE_OFF_FLAGS, f);
            exec(i[0] ? `CIGE_OP_ADD_ONE_WORD_OP : `CIGE_OP_INC, a & 32'hffff, 32'h0);
            b = inc_exp(a[15:0], i[0], f[7:0]);
            rchk(`CIGE_OFF_RESULT, i[0] ? 32'hffff : 32'hff, b & 32'hffff);
            if (i[0])
                check({31'h0, |(rd[15:8] | rd[7:0])}, {31'h0, a[15:0] != 16'hffff});
            rchk(`CIGE_OFF_FLAGS, 32'hff, b >> 16);
        end
        for (int i = 0; i < 8; i++)
        begin
            b = (i == 0) ? 32'hff : (rnd() | 32'h1) & 32'hff;
            t = (i == 0) ? 32'hff : rnd() & 32'hff;
            n = (i == 0) ? 8'hfe : 8'(rnd() % b);
            exec(`CIGE_OP_DIV, t * b + n, b);
            rchk(`CIGE_OFF_RESULT, 32'hffff, {16'h0, n, t[7:0]});
        end
        exec(`CIGE_OP_DIV, 32'h1234, 32'h0);
        rchk(`CIGE_OFF_STATUS, 32'h10, 32'h10);
        for (int i = 0; i < 8; i++)
        begin
            a = (i < 4) ? (32'h03020001 >> (i * 8)) & 32'hff : rnd() & 32'hff;
            b = (i < 4) ? (32'hfe807f05 >> (i * 8)) & 32'hff : rnd() & 32'hff;
            p = rnd() & 32'hfffe;
            f = rnd() & 32'hf0;
            n = a[7:0] - 8'h1;
            apb(1'b1, `CIGE_OFF_FLAGS, f);
            apb(1'b1, `CIGE_OFF_PC, p);
            exec(`CIGE_OP_LOOP, a, b);
            rchk(`CIGE_OFF_RESULT, 32'hff, {24'h0, n});
            t = p + 32'h2 + ((n != 8'h0) ? {{24{b[7]}}, b[7:0]} : 32'h0);
            rchk(`CIGE_OFF_PC, 32'hffff, t & 32'hffff);
            rchk(`CIGE_OFF_FLAGS, 32'hff, f);
        end
        exec(`CIGE_OP_IRQ_OFF, 32'h0, 32'h0);
        irq_req <= 8'h04;
        repeat (4) @(posedge pclk);
        irq_req <= 8'h00;
        repeat (4) @(posedge pclk);
        check({31'h0, irq_service}, 32'h0);
        rchk(`CIGE_OFF_IRQPEND, 32'hff, 32'h04);
        exec(`CIGE_OP_IRQ_ON, 32'h0, 32'h0);
        rchk(`CIGE_OFF_SYSMODE, 32'h1, 32'h1);
        check({31'h0, irq_service}, 32'h1);
        apb(1'b1, `CIGE_OFF_IRQPEND, 32'h04);
        repeat (3) @(posedge pclk);
        check({31'h0, irq_service}, 32'h0);
        rchk(`CIGE_OFF_FLAGS, 32'hff, f);
        p = rnd() & 32'h7e;
        t = (rnd() & 32'h7e) | 32'h80;
        a = rnd() & 32'hffff;
        b = rnd() & 32'hffff;
        apb(1'b1, `CIGE_OFF_MEMADDR, p);
        apb(1'b1, `CIGE_OFF_MEMDATA, a);
        apb(1'b1, `CIGE_OFF_MEMADDR, t);
        apb(1'b1, `CIGE_OFF_MEMDATA, b);
        apb(1'b1, `CIGE_OFF_PC, p);
        apb(1'b1, `CIGE_OFF_TCP, t);
        exec(`CIGE_OP_ENTER, 32'h0, 32'h0);
        rchk(`CIGE_OFF_STP, 32'hffff, 32'h00fe);
        rchk(`CIGE_OFF_PC, 32'hffff, a);
        rchk(`CIGE_OFF_TCP, 32'hffff, p + 32'h2);
        exec(`CIGE_OP_EXIT, 32'h0, 32'h0);
        rchk(`CIGE_OFF_STP, 32'hffff, 32'h0100);
        rchk(`CIGE_OFF_PC, 32'hffff, b);
        rchk(`CIGE_OFF_TCP, 32'hffff, t + 32'h2);
        rchk(`CIGE_OFF_FLAGS, 32'hff, f);
        apb(1'b1, `CIGE_OFF_CMD, {24'h0, `CIGE_OP_IDLE});
        repeat (3) @(posedge pclk);
        check({31'h0, cpu_clk_en}, 32'h0);
        irq_req <= 8'h10;
        for (int k = 0; k < 20 && cpu_clk_en !== 1'b1; k++)
            @(posedge pclk);
        check({31'h0, cpu_clk_en}, 32'h1);
        repeat (6) @(posedge pclk);
        irq_req <= 8'h00;
        repeat (6) @(posedge pclk);
        apb(1'b1, `CIGE_OFF_CMD, {24'h0, `CIGE_OP_IDLE});
        repeat (3) @(posedge pclk);
        check({31'h0, cpu_clk_en}, 32'h0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check({31'h0, cpu_clk_en}, 32'h1);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        check({31'h0, irq_service}, 32'h0);
        rchk(`CIGE_OFF_STATUS, 32'h7, 32'h0);
        rchk(`CIGE_OFF_STP, 32'hffff, 32'h0100);
        report_and_stop();
    end
endmodule
`default_nettype wire
